// ===== efuse_fault_pkg.sv
package efuse_fault_pkg;

    // ************************************************
    // timing
    // ************************************************
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned RETRY_TIME_US    = 100;
    localparam int unsigned RETRY_CYC        = RETRY_TIME_US * CLK_MHZ;
    localparam int unsigned PGA_TIME_US      = 10;
    localparam int unsigned PGA_CYC          = PGA_TIME_US * CLK_MHZ;
    localparam int unsigned PGA_EXTRA_US     = 100;
    localparam int unsigned PGA_EXTRA_CYC    = PGA_EXTRA_US * CLK_MHZ;
    localparam int unsigned PGD_TIME_US      = 10;
    localparam int unsigned PGD_CYC          = PGD_TIME_US * CLK_MHZ;
    localparam int unsigned SC_OFF_TIME_US   = 1;
    localparam int unsigned SC_OFF_CYC       = SC_OFF_TIME_US * CLK_MHZ;
    localparam int unsigned CNT_W            = 24;

    // ************************************************
    // register map (wishbone, byte addresses)
    // ************************************************
    localparam logic [3:0] CTRL_ADDR         = 4'h0;
    localparam logic [3:0] THRESH_ADDR       = 4'h4;
    localparam logic [3:0] STATUS_ADDR       = 4'h8;
    localparam int unsigned CTRL_RETRY_BIT   = 0;
    localparam int unsigned CTRL_SCFAST_BIT  = 1;
    localparam int unsigned CTRL_PGDLY_BIT   = 2;
    localparam int unsigned CTRL_IO1_BIT     = 3;
    localparam int unsigned CTRL_IO2_BIT     = 4;
    localparam logic [4:0] CTRL_RESET        = 5'h18;
    localparam logic [7:0] THRESH_RESET      = 8'h80;

    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,
        ST_INRUSH  = 3'b001,
        ST_STEADY  = 3'b010,
        ST_RETRY   = 3'b011,
        ST_LATCHED = 3'b100,
        ST_SC_OFF  = 3'b101
    } dev_state_t;

    typedef struct packed {
        logic       io2_is_fault;
        logic       io1_is_good;
        logic       good_extra_assert_delay;
        logic       short_circuit_fast_recovery;
        logic       auto_retry;
    } ctrl_t;

    typedef struct packed {
        logic       enable_ok;
        logic       enable_above_shutdown;
        logic       gate_full;
        logic       short_circuit;
        logic       other_fault;
    } sense_t;

endpackage

// ===== efuse_fault_response.sv
module efuse_fault_response
    import efuse_fault_pkg::*;
#(
    parameter int unsigned RETRY_CYCLES = RETRY_CYC,
    parameter int unsigned PGA_CYCLES   = PGA_CYC,
    parameter int unsigned PGA_EXTRA    = PGA_EXTRA_CYC,
    parameter int unsigned PGD_CYCLES   = PGD_CYC,
    parameter int unsigned SC_OFF_CYCLES = SC_OFF_CYC
) (
    input  wire logic        REF_CLK,        // 250 MHz clock
    input  wire logic        ARST_N,         // async reset, active low
    input  wire logic        POWER_OK,       // supply above undervoltage falling level
    input  wire logic        ENABLE_OK,      // enable above undervoltage level
    input  wire logic        ENABLE_ABOVE_SD,// enable above shutdown level
    input  wire logic        GATE_FULL,      // gate at full overdrive
    input  wire logic        SHORT_CIRCUIT,  // fast-trip event
    input  wire logic        OTHER_FAULT,    // non-short fault, latches unless auto_retry is set
    input  wire logic [7:0]  VOUT_LEVEL,     // output voltage code
    input  wire logic        SYNC_IN,        // sync line level

    input  wire logic [3:0]  WB_ADR_I,       // wishbone address
    input  wire logic [31:0] WB_DAT_I,       // wishbone write data
    output logic      [31:0] WB_DAT_O,       // wishbone read data
    input  wire logic        WB_WE_I,        // wishbone write enable
    input  wire logic [3:0]  WB_SEL_I,       // wishbone byte selects
    input  wire logic        WB_CYC_I,       // wishbone cycle
    input  wire logic        WB_STB_I,       // wishbone strobe
    output logic             WB_ACK_O,       // wishbone acknowledge

    output logic             SWITCH_ON,      // fet driver enable
    output logic             SLEW_START,     // slew-limited startup request
    output logic             CURRENT_LIMITED,// current-limited startup request
    output logic             SYNC_OUT,       // sync line drive value
    output logic             SYNC_OE_N,      // sync line drive enable, low drives
    output logic             IO1_OUT,        // general io one output value
    output logic             IO1_OE_N,       // general io one enable, low drives
    output logic             IO2_OUT,        // general io two output value
    output logic             IO2_OE_N        // general io two enable, low drives
);

    // ************************************************
    // input synchronisers
    // ************************************************
    sense_t     sense_meta;
    sense_t     sense;
    logic [1:0] pwr_sync;
    logic [1:0] sync_line;
    logic [7:0] vout_meta;
    logic [7:0] vout;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sense_meta <= '0;
            sense      <= '0;
            pwr_sync   <= 2'h0;
            sync_line  <= 2'h0;
            vout_meta  <= 8'h00;
            vout       <= 8'h00;
        end else begin
            sense_meta.enable_ok             <= ENABLE_OK;
            sense_meta.enable_above_shutdown <= ENABLE_ABOVE_SD;
            sense_meta.gate_full             <= GATE_FULL;
            sense_meta.short_circuit         <= SHORT_CIRCUIT;
            sense_meta.other_fault           <= OTHER_FAULT;
            sense      <= sense_meta;
            pwr_sync   <= {pwr_sync[0], POWER_OK};
            sync_line  <= {sync_line[0], SYNC_IN};
            vout_meta  <= VOUT_LEVEL;
            vout       <= vout_meta;
        end
    end

    // ************************************************
    // registers
    // ************************************************
    ctrl_t      ctrl;
    logic [7:0] output_good_threshold;
    logic       wb_req;
    logic       wb_wr;

    assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    // write lands at the edge where the master sees ack
    assign wb_wr  = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_SEL_I[0];

    // ************************************************
    // control register
    // ************************************************

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl <= CTRL_RESET;
        end else if (wb_wr && WB_ADR_I == CTRL_ADDR) begin
            ctrl <= WB_DAT_I[4:0];
        end
    end

    // ************************************************
    // threshold register
    // ************************************************

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            output_good_threshold <= THRESH_RESET;
        end else if (wb_wr && WB_ADR_I == THRESH_ADDR) begin
            output_good_threshold <= WB_DAT_I[7:0];
        end
    end

    // ************************************************
    // fault state machine
    // ************************************************
    dev_state_t          state;
    dev_state_t          next_state;
    logic [CNT_W-1:0]    timer;
    logic                fault_indicator_n;
    logic                clear_event;
    logic                ext_pull;

    // ************************************************
    // clearing and external pull
    // ************************************************

    logic [2:0]          release_hist;

    // the synchronised line lags our own release by two flops,
    // so a low level is trusted only once the release has stood
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            release_hist <= 3'h0;
        end else begin
            release_hist <= {release_hist[1:0], SYNC_OE_N};
        end
    end

    assign clear_event = !pwr_sync[1] || !sense.enable_above_shutdown;
    // external pull-low seen while we release the line
    assign ext_pull    = (state == ST_INRUSH || state == ST_STEADY) && (&release_hist) && !sync_line[1];

    // ************************************************
    // next state
    // ************************************************

    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF: begin
                if (sense.enable_ok) begin
                    next_state = ST_INRUSH;
                end
            end
            ST_INRUSH, ST_STEADY: begin
                if (!sense.enable_ok) begin
                    next_state = ST_OFF;
                end else if (sense.short_circuit && ctrl.short_circuit_fast_recovery) begin
                    next_state = ST_SC_OFF;
                end else if (sense.short_circuit || sense.other_fault || ext_pull) begin
                    next_state = ctrl.auto_retry ? ST_RETRY : ST_LATCHED;
                end else if (state == ST_INRUSH && sense.gate_full) begin
                    next_state = ST_STEADY;
                end
            end
            ST_RETRY: begin
                if (timer >= CNT_W'(RETRY_CYCLES - 1)) begin
                    next_state = ST_OFF;
                end
            end
            ST_LATCHED: next_state = ST_LATCHED;
            ST_SC_OFF: begin
                if (timer >= CNT_W'(SC_OFF_CYCLES - 1)) begin
                    next_state = ST_INRUSH;
                end
            end
            default: next_state = ST_OFF;
        endcase
        // only shutdown or power cycle clears
        if (clear_event) begin
            next_state = ST_OFF;
        end
    end

    // ************************************************
    // state register
    // ************************************************

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************
    // retry and recovery timer
    // ************************************************

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            timer <= '0;
        end else if (next_state != state) begin
            timer <= '0;
        end else if (state == ST_RETRY || state == ST_SC_OFF) begin
            timer <= timer + 1'b1;
        end
    end

    // ************************************************
    // fault indicator
    // ************************************************

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            fault_indicator_n <= 1'b1;
        end else begin
            fault_indicator_n <= !(next_state == ST_RETRY || next_state == ST_LATCHED);
        end
    end

    // ************************************************
    // switch and sync line
    // ************************************************

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            SWITCH_ON <= 1'b0;
            SYNC_OUT  <= 1'b0;
            SYNC_OE_N <= 1'b0;
        end else begin
            SWITCH_ON <= next_state == ST_INRUSH || next_state == ST_STEADY;
            SYNC_OUT  <= 1'b0;
            SYNC_OE_N <= next_state == ST_INRUSH || next_state == ST_STEADY;
        end
    end

    // ************************************************
    // startup style
    // ************************************************

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            SLEW_START      <= 1'b0;
            CURRENT_LIMITED <= 1'b0;
        end else if (next_state == ST_INRUSH && state != ST_INRUSH) begin
            SLEW_START      <= state != ST_SC_OFF;
            CURRENT_LIMITED <= state == ST_SC_OFF;
        end else if (next_state != ST_INRUSH) begin
            SLEW_START      <= 1'b0;
            CURRENT_LIMITED <= 1'b0;
        end
    end

    // ************************************************
    // power good with deglitch
    // ************************************************
    logic             power_good_out;
    logic             good_raw;
    logic [CNT_W-1:0] good_cnt;
    logic [CNT_W-1:0] good_assert_cyc;

    // ************************************************
    // raw condition
    // ************************************************

    // raw good, a short circuit drops it by taking the state out of steady
    assign good_raw = state == ST_STEADY
                   && !sense.other_fault
                   && vout >= output_good_threshold;
    assign good_assert_cyc = ctrl.good_extra_assert_delay ? CNT_W'(PGA_CYCLES + PGA_EXTRA)
                                                          : CNT_W'(PGA_CYCLES);

    // ************************************************
    // deglitch
    // ************************************************

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            good_cnt       <= '0;
            power_good_out <= 1'b0;
        end else if (good_raw == power_good_out) begin
            good_cnt <= '0;
        end else if (good_cnt >= (power_good_out ? CNT_W'(PGD_CYCLES - 1) : good_assert_cyc - 1'b1)) begin
            good_cnt       <= '0;
            power_good_out <= good_raw;
        end else begin
            good_cnt <= good_cnt + 1'b1;
        end
    end

    // ************************************************
    // pin mapping, open drain
    // ************************************************

    // general io one carries power good by default
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            IO1_OUT  <= 1'b0;
            IO1_OE_N <= 1'b0;
        end else begin
            IO1_OUT  <= 1'b0;
            IO1_OE_N <= ctrl.io1_is_good ? power_good_out : 1'b1;
        end
    end

    // general io two carries the fault indicator by default
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            IO2_OUT  <= 1'b0;
            IO2_OE_N <= 1'b1;
        end else begin
            IO2_OUT  <= 1'b0;
            IO2_OE_N <= ctrl.io2_is_fault ? fault_indicator_n : 1'b1;
        end
    end

    // ************************************************
    // wishbone read and ack
    // ************************************************
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= wb_req;
        end
    end

    // read data registered so it stands through the ack cycle
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WB_DAT_O <= 32'h0;
        end else if (wb_req && !WB_WE_I) begin
            unique case (WB_ADR_I)
                CTRL_ADDR:   WB_DAT_O <= {27'h0, ctrl};
                THRESH_ADDR: WB_DAT_O <= {24'h0, output_good_threshold};
                STATUS_ADDR: WB_DAT_O <= {26'h0, power_good_out, fault_indicator_n, 1'b0, state};
                default:     WB_DAT_O <= 32'h0;
            endcase
        end
    end

endmodule

// ===== efuse_fault_response_properties.sv
// ****************
// pin relations
// ****************
module efuse_fault_checker #(
    parameter int PGA_CYCLES = 8,
    parameter int PGD_CYCLES = 8
) (
    input wire logic REF_CLK,         // clock
    input wire logic ARST_N,          // reset
    input wire logic SWITCH_ON,       // fet on
    input wire logic SLEW_START,      // slew start
    input wire logic CURRENT_LIMITED, // limited start
    input wire logic SYNC_OUT,        // sync value
    input wire logic SYNC_OE_N,       // sync drive
    input wire logic IO1_OUT,         // io1 value
    input wire logic IO1_OE_N,        // io1 drive
    input wire logic IO2_OUT,         // io2 value
    input wire logic IO2_OE_N,        // io2 drive
    input wire logic WB_ACK_O         // ack
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PGD_MAX = PGD_CYCLES + 8;
    int steady_cnt;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    // steady run length as seen at the pins
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            steady_cnt <= 0;
        end else if (SWITCH_ON && !SLEW_START && !CURRENT_LIMITED) begin
            steady_cnt <= steady_cnt + 1;
        end else begin
            steady_cnt <= 0;
        end
    end
    property p_sync_drive; !SWITCH_ON |-> !SYNC_OE_N; endproperty
    a_sync_drive: assert property (p_sync_drive) else $error("sync line not held low");
    property p_open_drain; !SYNC_OUT && !IO1_OUT && !IO2_OUT; endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain value high");
    property p_slew; $rose(SWITCH_ON) |-> SLEW_START || CURRENT_LIMITED; endproperty
    a_slew: assert property (p_slew) else $error("start without startup mode");
    property p_pg_inrush; SLEW_START |-> !IO1_OE_N; endproperty
    a_pg_inrush: assert property (p_pg_inrush) else $error("good high in inrush");
    property p_pg_rise; $rose(IO1_OE_N) |-> steady_cnt >= PGA_CYCLES - 1; endproperty
    a_pg_rise: assert property (p_pg_rise) else $error("good rose early");
    property p_pg_fall; $fell(SWITCH_ON) ##1 (!SWITCH_ON)[*8] |-> ##[0:PGD_MAX] !IO1_OE_N; endproperty
    a_pg_fall: assert property (p_pg_fall) else $error("good not dropped");
    property p_fault_off; !IO2_OE_N |-> !SWITCH_ON; endproperty
    a_fault_off: assert property (p_fault_off) else $error("switch on with fault");
    property p_ack_one; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
endmodule

// ===== efuse_host_model.sv
// ****************
// host side pins
// ****************
module efuse_host_model (
    input  wire logic sync_out,  // sync value
    input  wire logic sync_oe_n, // sync drive
    input  wire logic io1_out,   // io1 value
    input  wire logic io1_oe_n,  // io1 drive
    input  wire logic io2_out,   // io2 value
    input  wire logic io2_oe_n,  // io2 drive
    input  wire logic sec_pull,  // secondary pulls sync
    output logic      sync_line, // sync wire level
    output logic      good,      // good wire level
    output logic      fault_n    // fault wire level
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-ups: a released pin reads high
    assign good = io1_oe_n ? 1'b1 : io1_out;
    assign fault_n = io2_oe_n ? 1'b1 : io2_out;
    assign sync_line = (sec_pull || (!sync_oe_n && !sync_out)) ? 1'b0 : 1'b1;
endmodule

// ===== efuse_fault_response_tb.sv
module efuse_fault_response_tb;
    import efuse_fault_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PGA = 8;
    localparam int PGD = 8;
    localparam int EXTRA = 8;
    localparam int RETRY = 20;
    localparam int SCOFF = 4;
    logic        ref_clk, arst_n, pwr_ok, en_ok, en_sd, gate, sc, oflt, sec_pull, cyc, stb, we, ack;
    logic        sw_on, slew, climit, sync_out, sync_oe_n, io1_out, io1_oe_n, io2_out, io2_oe_n;
    logic        sync_line, good, fault_n;
    logic [3:0]  adr, sel;
    logic [7:0]  vout;
    logic [31:0] wdat, rdat, rd;
    int          failures, total_checks, cycles;
    efuse_fault_response #(.RETRY_CYCLES(RETRY), .PGA_CYCLES(PGA), .PGA_EXTRA(EXTRA), .PGD_CYCLES(PGD),
        .SC_OFF_CYCLES(SCOFF)) efuse_fault_response_inst (.REF_CLK(ref_clk), .ARST_N(arst_n), .POWER_OK(pwr_ok),
        .ENABLE_OK(en_ok), .ENABLE_ABOVE_SD(en_sd), .GATE_FULL(gate), .SHORT_CIRCUIT(sc), .OTHER_FAULT(oflt),
        .VOUT_LEVEL(vout), .SYNC_IN(sync_line), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_WE_I(we),
        .WB_SEL_I(sel), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack), .SWITCH_ON(sw_on), .SLEW_START(slew),
        .CURRENT_LIMITED(climit), .SYNC_OUT(sync_out), .SYNC_OE_N(sync_oe_n), .IO1_OUT(io1_out),
        .IO1_OE_N(io1_oe_n), .IO2_OUT(io2_out), .IO2_OE_N(io2_oe_n));
    efuse_host_model efuse_host_model_inst (.sync_out(sync_out), .sync_oe_n(sync_oe_n), .io1_out(io1_out),
        .io1_oe_n(io1_oe_n), .io2_out(io2_out), .io2_oe_n(io2_oe_n), .sec_pull(sec_pull),
        .sync_line(sync_line), .good(good), .fault_n(fault_n));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // hang guard well above the whole sequence
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_range(input int n, input int lo, input int hi);
        total_checks++;
        if (n < lo || n > hi) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h..%h", $time, n, lo, hi);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return good;
            1: return fault_n;
            2: return sw_on;
            3: return climit;
            default: return slew;
        endcase
    endfunction
    task automatic wait_for(input int s, input logic v, output int n);
        n = 0;
        while (pick(s) !== v && n < 500) begin
            @(posedge ref_clk);
            n++;
        end
    endtask
    task automatic t_regs();
        wb(0, CTRL_ADDR, 0);
        chk(rd, {27'h0, CTRL_RESET});
        chk({30'h0, good, fault_n}, 32'h1);
        wb(0, THRESH_ADDR, 0);
        chk(rd, {24'h0, THRESH_RESET});
        wb(0, 4'hc, 0);
        chk(rd, 32'h0);
        wb(1, THRESH_ADDR, 32'h40);
        wb(0, THRESH_ADDR, 0);
        chk(rd, 32'h40);
    endtask
    task automatic t_start();
        int n;
        @(posedge ref_clk);
        en_ok <= 1'b1;
        en_sd <= 1'b1;
        wait_for(4, 1'b1, n);
        chk({31'h0, good}, 32'h0);
        @(posedge ref_clk);
        gate <= 1'b1;
        wait_for(0, 1'b1, n);
        chk_range(n, PGA, PGA + 8);
        wb(0, STATUS_ADDR, 0);
        chk(rd & 32'h7, 32'h2);
    endtask
    task automatic t_pg();
        int n;
        wb(1, CTRL_ADDR, 32'h1c);
        @(posedge ref_clk);
        vout <= 8'h30;
        wait_for(0, 1'b0, n);
        chk_range(n, PGD, PGD + 8);
        @(posedge ref_clk);
        vout <= 8'h50;
        wait_for(0, 1'b1, n);
        chk_range(n, PGA + EXTRA, PGA + EXTRA + 8);
        wb(1, CTRL_ADDR, 32'h18);
    endtask
    task automatic t_fault(input logic [31:0] mode);
        wb(1, CTRL_ADDR, mode);
        @(posedge ref_clk);
        oflt <= 1'b1;
        gate <= 1'b0;
        @(posedge ref_clk);
        oflt <= 1'b0;
    endtask
    task automatic t_latch();
        int n;
        t_fault(32'h18);
        en_ok <= 1'b0;
        repeat (60) @(posedge ref_clk);
        chk({30'h0, fault_n, sw_on}, 32'h0);
        wb(0, STATUS_ADDR, 0);
        chk(rd & 32'h7, 32'h4);
        en_sd <= 1'b0;
        wait_for(1, 1'b1, n);
        chk_range(n, 1, 8);
        t_start();
    endtask
    task automatic t_retry();
        int n;
        t_fault(32'h19);
        wait_for(1, 1'b0, n);
        wait_for(1, 1'b1, n);
        chk_range(n, RETRY - 1, RETRY + 2);
        wait_for(4, 1'b1, n);
        chk_range(n, 0, 2);
        wb(1, CTRL_ADDR, 32'h18);
        t_start();
    endtask
    task automatic t_fast();
        int n;
        wb(1, CTRL_ADDR, 32'h1a);
        @(posedge ref_clk);
        sc <= 1'b1;
        @(posedge ref_clk);
        sc <= 1'b0;
        wait_for(2, 1'b0, n);
        wait_for(3, 1'b1, n);
        chk_range(n, SCOFF - 1, SCOFF + 2);
        chk({31'h0, fault_n}, 32'h1);
        chk({31'h0, good}, 32'h1);
        wb(1, CTRL_ADDR, 32'h18);
        wait_for(0, 1'b1, n);
    endtask
    task automatic t_sync();
        int n;
        @(posedge ref_clk);
        sec_pull <= 1'b1;
        gate <= 1'b0;
        wait_for(2, 1'b0, n);
        @(posedge ref_clk);
        sec_pull <= 1'b0;
        repeat (30) @(posedge ref_clk);
        chk({30'h0, fault_n, sw_on}, 32'h0);
        chk({31'h0, sync_line}, 32'h0);
        pwr_ok <= 1'b0;
        wait_for(1, 1'b1, n);
        chk_range(n, 1, 8);
        pwr_ok <= 1'b1;
        t_start();
    endtask
    initial begin
        {arst_n, en_ok, en_sd, gate, sc, oflt, sec_pull, cyc, stb, we} = '0;
        {pwr_ok, adr, sel, wdat, vout} = {1'b1, 4'h0, 4'hf, 32'h0, 8'h90};
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_regs();
        t_start();
        t_pg();
        t_latch();
        t_retry();
        t_fast();
        t_sync();
        report_and_stop();
    end
endmodule
bind efuse_fault_response efuse_fault_checker #(.PGA_CYCLES(PGA_CYCLES), .PGD_CYCLES(PGD_CYCLES))
    efuse_fault_checker_inst (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .SWITCH_ON(SWITCH_ON), .SLEW_START(SLEW_START),
    .CURRENT_LIMITED(CURRENT_LIMITED), .SYNC_OUT(SYNC_OUT), .SYNC_OE_N(SYNC_OE_N), .IO1_OUT(IO1_OUT),
    .IO1_OE_N(IO1_OE_N), .IO2_OUT(IO2_OUT), .IO2_OE_N(IO2_OE_N), .WB_ACK_O(WB_ACK_O));
